// ===== dv/spi_peer_model.sv
/*
  behavioural spi peer for the transaction sequencer in master mode.
  assumes the clock and select come from the sequencer's pins.
*/
`timescale 1ns/1ps
module spi_peer_model (
  // pins from the sequencer
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        mosi_i,
  // setup
  input  wire logic        cpol_i,
  input  wire logic [31:0] pattern_i,
  // pins to the sequencer and observations
  output logic             miso_o,
  output logic      [63:0] seen_o,
  output int               n_lead_o
);
  int idx;

  initial begin
    miso_o = 1'b0;
    seen_o = '0;
    n_lead_o = 0;
    idx = 0;
  end

  always @(negedge cs_n_i) begin
    n_lead_o = 0;
    idx = 0;
    seen_o = '0;
    miso_o = pattern_i[31];
  end

  // released line shows the inverse of its last value
  always @(posedge cs_n_i) miso_o = ~miso_o;

  // sample on the leading edge, shift out on the trailing edge
  always @(sclk_i) begin
    if (!cs_n_i && sclk_i !== cpol_i) begin
      seen_o = {seen_o[62:0], mosi_i};
      n_lead_o = n_lead_o + 1;
    end else if (!cs_n_i) begin
      idx = idx + 1;
      miso_o = (idx < 32) ? pattern_i[31-idx] : ~miso_o;
    end
  end
endmodule

// ===== dv/tb.sv
/*
  self-checking bench for the spi transaction sequencer.
  assumes the register port and pin carriers of the design package.
*/
`timescale 1ns/1ps
module tb;
  import spi_phase_pkg::*;
  logic        ref_clk_i, reset_i, wr_i, rd_i, rd_seen;
  logic [7:0]  addr_i;
  logic [31:0] wr_data_i, rd_data_o, r0, r1, pat;
  logic        s_sclk, s_cs_n, s_mosi, miso, cpol;
  logic [63:0] seen, note;
  logic [63:0] q[$];
  int          n_lead, n_mismatch, checks, cyc;
  spi_in_s     pins_i;
  spi_out_s    pins_o;

  assign pins_i = {s_sclk, s_cs_n, s_mosi, miso};

  spi_transaction_phase_config DUT (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .spi_pins_i(pins_i), .spi_pins_o(pins_o));
  spi_peer_model peer (.sclk_i(pins_o.sclk), .cs_n_i(pins_o.cs_n),
    .mosi_i(pins_o.mosi), .cpol_i(cpol), .pattern_i(pat),
    .miso_o(miso), .seen_o(seen), .n_lead_o(n_lead));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task chk(input string nm, input logic [31:0] sv, input logic [31:0] ev);
    checks++;
    if (sv !== ev) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, ev, sv);
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task bus(input logic w, input logic r, input logic [7:0] a,
           input logic [31:0] d);
    @(posedge ref_clk_i);
    wr_i <= w;
    rd_i <= r;
    addr_i <= a;
    wr_data_i <= d;
  endtask

  task rd_exp(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back({e, m});
    bus(1'b0, 1'b1, a, 32'h0000_0000);
  endtask

  // start a master transaction and wait for select to rise
  task frame;
    bus(1'b1, 1'b0, OFS_CTRL, 32'h0004_0000);
    bus(1'b0, 1'b0, OFS_CTRL, 32'h0000_0000);
    for (int i = 0; i < 8 && pins_o.cs_n !== 1'b0; i++) @(posedge ref_clk_i);
    for (int i = 0; i < 2000 && pins_o.cs_n !== 1'b1; i++)
      @(posedge ref_clk_i);
    repeat (2) @(posedge ref_clk_i);
  endtask

  // read results: oldest note against the data after each read
  always @(posedge ref_clk_i) begin
    if (rd_seen) begin
      note = q.pop_front();
      chk("read", rd_data_o & note[31:0], note[63:32] & note[31:0]);
    end
    rd_seen <= rd_i;
  end

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    reset_i = 1'b1;
    {wr_i, rd_i, rd_seen, s_sclk, s_mosi, cpol} = '0;
    s_cs_n = 1'b1;
    addr_i = 8'h00;
    wr_data_i = 32'h0000_0000;
    {n_mismatch, checks, cyc} = '0;
    void'($urandom(77142));
    r0 = $urandom;
    r1 = $urandom;
    pat = $urandom;
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rd_exp(OFS_USER, USER_RST, 32'hFFFF_FFFF);
    rd_exp(OFS_USER1, USER1_RST, 32'hFFFF_FFFF);
    rd_exp(OFS_USER2, USER2_RST, 32'hFFFF_FFFF);
    rd_exp(OFS_TXLEN, ZERO_RST, 32'hFFFF_FFFF);
    rd_exp(OFS_RXLEN, ZERO_RST, 32'hFFFF_FFFF);
    rd_exp(8'h50, ZERO_RST, 32'hFFFF_FFFF);
    bus(1'b1, 1'b0, OFS_USER1, {r1[31:26], 18'h0, 8'h03});
    rd_exp(OFS_USER1, 32'h5C00_0003, 32'hFC00_00FF);
    $display("test registers done");
    // command, write and read phases, little endian, rx to upper half
    bus(1'b1, 1'b0, OFS_USER, 32'h9900_0000);
    bus(1'b1, 1'b0, OFS_USER2, 32'h7000_00A5);
    bus(1'b1, 1'b0, OFS_TXLEN, 32'h0000_000F);
    bus(1'b1, 1'b0, OFS_RXLEN, 32'h0000_0007);
    bus(1'b1, 1'b0, 8'h80, r0);
    frame();
    chk("edges", n_lead, 32);
    chk("mosi", seen[31:8], {8'hA5, r0[7:0], r0[15:8]});
    chk("idle clock", pins_o.sclk, 1'b0);
    rd_exp(8'hA0, pat, 32'h0000_00FF);
    $display("test command write read done");
    // gated dummy, big-endian write from upper half, idle high clock
    cpol = 1'b1;
    bus(1'b1, 1'b0, OFS_PINCFG, 32'h0000_0002);
    bus(1'b1, 1'b0, OFS_USER, 32'h2E00_0800);
    bus(1'b1, 1'b0, 8'hA0, r1);
    frame();
    chk("edges", n_lead, 16);
    chk("mosi", seen[15:0], r1[31:16]);
    chk("idle clock", pins_o.sclk, 1'b1);
    $display("test dummy write done");
    // slave receive with the link clock at 320 ns
    bus(1'b1, 1'b0, OFS_PINCFG, 32'h0000_0001);
    bus(1'b1, 1'b0, OFS_USER, 32'h0000_0000);
    bus(1'b0, 1'b0, OFS_CTRL, 32'h0000_0000);
    s_cs_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      s_mosi <= pat[i+8];
      repeat (4) @(posedge ref_clk_i);
      s_sclk <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      s_sclk <= 1'b0;
    end
    chk("miso_oe", pins_o.miso_oe, 1'b1);
    chk("mosi_oe", pins_o.mosi_oe, 1'b0);
    repeat (4) @(posedge ref_clk_i);
    s_cs_n <= 1'b1;
    s_mosi <= ~s_mosi;
    repeat (8) @(posedge ref_clk_i);
    rd_exp(8'h80, {24'h0, pat[15:8]}, 32'h0000_00FF);
    bus(1'b0, 1'b0, OFS_CTRL, 32'h0000_0000);
    repeat (3) @(posedge ref_clk_i);
    $display("test slave receive done");
    print_verdict();
  end
endmodule

// ===== hdl/pin_sync3.sv
/*
  three-stage synchroniser for pin inputs.
  assumes inputs change slowly against the reference clock.
*/
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  // pins
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // output follows only once second and third stage agree
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      sync_o <= '0;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          sync_o[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule

// ===== hdl/spi_phase_pkg.sv
/*
  constants, states and pin carriers for the spi transaction sequencer.
  assumes a 25 mhz reference clock and an 8-bit word-aligned register port.
*/
package spi_phase_pkg;

  // register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_USER   = 8'h1C;
  localparam logic [7:0] OFS_USER1  = 8'h20;
  localparam logic [7:0] OFS_USER2  = 8'h24;
  localparam logic [7:0] OFS_TXLEN  = 8'h28;
  localparam logic [7:0] OFS_RXLEN  = 8'h2C;
  localparam logic [7:0] OFS_PINCFG = 8'h34;
  localparam logic [7:0] OFS_STATUS = 8'hF8;
  localparam logic [1:0] BUF_TAG    = 2'h2;

  // transaction_user_control fields, and the start bit of the control register
  localparam int B_CMD_EN     = 31;
  localparam int B_ADDR_EN    = 30;
  localparam int B_DUMMY_EN   = 29;
  localparam int B_RD_EN      = 28;
  localparam int B_WR_EN      = 27;
  localparam int B_DUMMY_GATE = 26;
  localparam int B_TX_UPPER   = 25;
  localparam int B_RX_UPPER   = 24;
  localparam int B_THREE_LINE = 16;
  localparam int B_WR_BE      = 11;
  localparam int B_RD_BE      = 10;
  localparam int B_OUT_EDGE   = 7;
  localparam int B_IN_EDGE    = 6;
  localparam int B_CS_SETUP   = 5;
  localparam int B_CS_HOLD    = 4;
  localparam int B_FULL_DUP   = 0;
  localparam int B_START      = 18;

  // field positions in the other registers
  localparam int F_ADDR_LEN_LSB  = 26;
  localparam int F_CMD_LEN_LSB   = 28;
  localparam int F_SLAVE         = 0;
  localparam int F_IDLE_LEVEL    = 1;
  localparam int F_SETUP_LSB     = 2;
  localparam int F_HOLD_LSB      = 6;
  localparam int F_OUT_DLY_LSB   = 10;
  localparam int F_IN_DLY_LSB    = 12;

  // values after reset
  localparam logic [31:0] USER_RST   = 32'h8000_0040;
  localparam logic [31:0] USER1_RST  = 32'h5C00_0007;
  localparam logic [31:0] USER2_RST  = 32'h7000_0000;
  localparam logic [31:0] ZERO_RST   = 32'h0000_0000;

  // timing, in reference cycles and spi half periods
  localparam int REF_MHZ         = 25;
  localparam int SPI_KHZ         = 6250;
  localparam int HALF_CYCLES     = (REF_MHZ * 1000) / (2 * SPI_KHZ);
  localparam int SETUP_EXTRA_HLF = 3;
  localparam int FD_ODD_HLF      = 2;
  localparam int SYNC_LAT        = 4;

  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_SETUP = 9'h002,
    ST_CMD   = 9'h004,
    ST_ADDR  = 9'h008,
    ST_DUMMY = 9'h010,
    ST_WRITE = 9'h020,
    ST_READ  = 9'h040,
    ST_HOLD  = 9'h080,
    ST_DONE  = 9'h100
  } seq_state_e;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
  } spi_out_s;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
  } spi_in_s;

endpackage

// ===== hdl/spi_transaction_phase_config.sv
/*
  spi transaction sequencer with phase configuration and 16-word buffer.
  assumes a single-cycle register port and an external spi partner whose
  pins are sampled through four flip-flops.
*/
`timescale 1ns/1ps
module spi_transaction_phase_config (
  // clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_i,
  // register port
  input  wire logic [7:0]              addr_i,
  input  wire logic [31:0]             wr_data_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [31:0]             rd_data_o,
  // spi pins
  input  wire spi_phase_pkg::spi_in_s  spi_pins_i,
  output spi_phase_pkg::spi_out_s      spi_pins_o
);
  import spi_phase_pkg::*;

  logic [31:0] user_reg, user1_reg, user2_reg, txlen_reg, rxlen_reg;
  logic [31:0] addr_val_reg, pincfg_reg;
  logic [31:0] buf_reg [16];
  seq_state_e  state_reg, state_next;
  logic [3:0]  div_reg;
  logic        ph_reg;
  logic [8:0]  idx_reg;
  logic [23:0] cnt_reg;
  logic [5:0]  wait_reg;
  logic        mosi_reg;
  spi_in_s     pin_s;
  logic        s_sclk_prev_reg;
  logic [8:0]  s_idx_reg;

  // field views
  wire logic full_dup   = user_reg[B_FULL_DUP];
  wire logic slave_mode = pincfg_reg[F_SLAVE];
  wire logic idle_lvl   = pincfg_reg[F_IDLE_LEVEL];
  wire logic out_eff    = user_reg[B_OUT_EDGE] ^ pincfg_reg[F_OUT_DLY_LSB];
  wire logic in_eff     = user_reg[B_IN_EDGE] ^ pincfg_reg[F_IN_DLY_LSB];
  wire logic [3:0] setup_t = pincfg_reg[F_SETUP_LSB +: 4];
  wire logic [3:0] hold_t  = pincfg_reg[F_HOLD_LSB +: 4];
  wire logic [5:0] addr_m1 = user1_reg[F_ADDR_LEN_LSB +: 6];
  wire logic [7:0] dummy_m1 = user1_reg[7:0];
  wire logic [3:0] cmd_m1  = user2_reg[F_CMD_LEN_LSB +: 4];
  wire logic [15:0] cmd_val = user2_reg[15:0];
  wire logic [3:0] tx_base = {user_reg[B_TX_UPPER], 3'h0};
  wire logic [3:0] rx_base = {user_reg[B_RX_UPPER], 3'h0};

  // phase enables; full duplex keeps only the data exchange
  wire logic en_cmd   = user_reg[B_CMD_EN] & ~full_dup;
  wire logic en_addr  = user_reg[B_ADDR_EN] & ~full_dup;
  wire logic en_dummy = user_reg[B_DUMMY_EN] & ~full_dup;
  wire logic en_wr    = user_reg[B_WR_EN];
  wire logic en_rd    = user_reg[B_RD_EN] & ~full_dup;

  // bus decode
  wire logic hit_buf   = addr_i[7:6] == BUF_TAG;
  wire logic start_req = wr_i & (addr_i == OFS_CTRL) & wr_data_i[B_START]
                         & (state_reg == ST_IDLE) & ~slave_mode;
  wire logic bit_phase = state_reg inside {ST_CMD, ST_ADDR, ST_WRITE,
                                           ST_READ};

  // bit position inside a 32-bit word for a stream index
  function automatic logic [4:0] lane_pos(input logic [4:0] k,
                                          input logic be);
    lane_pos = {be ? ~k[4:3] : k[4:3], ~k[2:0]};
  endfunction

  pin_sync3 #(.WIDTH(4)) u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   (spi_pins_i),
    .sync_o    (pin_s)
  );

  // half-period tick of the spi clock
  wire logic half_tick = div_reg == 4'(HALF_CYCLES - 1);
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || state_reg == ST_IDLE) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= half_tick ? 4'h0 : div_reg + 4'h1;
    end
  end

  wire logic lead_tick  = half_tick & bit_phase & ~ph_reg;
  wire logic trail_tick = half_tick & bit_phase & ph_reg;
  wire logic last_bit   = cnt_reg == 24'h0;

  // first enabled phase at or after a position
  function automatic seq_state_e pick(input int from, input logic c,
                                      input logic a, input logic d,
                                      input logic w, input logic r);
    if (from <= 0 && c) pick = ST_CMD;
    else if (from <= 1 && a) pick = ST_ADDR;
    else if (from <= 2 && d) pick = ST_DUMMY;
    else if (from <= 3 && w) pick = ST_WRITE;
    else if (from <= 4 && r) pick = ST_READ;
    else pick = ST_HOLD;
  endfunction

  // master sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_req) state_next = ST_SETUP;
      end
      ST_SETUP: begin
        if (half_tick && wait_reg == 6'h0) begin
          state_next = pick(0, en_cmd, en_addr, en_dummy, en_wr, en_rd);
        end
      end
      ST_CMD: begin
        if (trail_tick && last_bit) begin
          state_next = pick(1, en_cmd, en_addr, en_dummy, en_wr, en_rd);
        end
      end
      ST_ADDR: begin
        if (trail_tick && last_bit) begin
          state_next = pick(2, en_cmd, en_addr, en_dummy, en_wr, en_rd);
        end
      end
      ST_DUMMY: begin
        if (half_tick && ph_reg && last_bit) begin
          state_next = pick(3, en_cmd, en_addr, en_dummy, en_wr, en_rd);
        end
      end
      ST_WRITE: begin
        if (trail_tick && last_bit) begin
          state_next = pick(4, en_cmd, en_addr, en_dummy, en_wr, en_rd);
        end
      end
      ST_READ: begin
        if (trail_tick && last_bit) state_next = ST_HOLD;
      end
      ST_HOLD: begin
        if (half_tick && wait_reg == 6'h0) state_next = ST_DONE;
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // length of the phase being entered, minus one
  logic [23:0] len_next;
  always_comb begin
    len_next = 24'h0;
    case (state_next)
      ST_CMD:   len_next = {20'h0, cmd_m1};
      ST_ADDR:  len_next = {18'h0, addr_m1};
      ST_DUMMY: len_next = {16'h0, dummy_m1};
      ST_WRITE: len_next = txlen_reg[23:0];
      ST_READ:  len_next = rxlen_reg[23:0];
      default:  len_next = 24'h0;
    endcase
  end

  // lead-in before the first edge, in half periods
  logic [5:0] setup_hlf;
  always_comb begin
    if (user_reg[B_CS_SETUP]) begin
      setup_hlf = 6'({setup_t, 1'b0}) + 6'(SETUP_EXTRA_HLF);
    end else if (full_dup && out_eff) begin
      setup_hlf = 6'(FD_ODD_HLF);
    end else begin
      setup_hlf = 6'(SETUP_EXTRA_HLF);
    end
  end

  wire logic phase_change = state_next != state_reg;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      ph_reg    <= 1'b0;
      cnt_reg   <= 24'h0;
      idx_reg   <= 9'h0;
      wait_reg  <= 6'h0;
    end else begin
      state_reg <= state_next;
      if (phase_change) begin
        ph_reg  <= 1'b0;
        cnt_reg <= len_next;
        idx_reg <= 9'h0;
        if (state_next == ST_SETUP) wait_reg <= setup_hlf - 6'h1;
        if (state_next == ST_HOLD) begin
          wait_reg <= user_reg[B_CS_HOLD] ? {1'b0, hold_t, 1'b0} : 6'h0;
        end
      end else if (half_tick) begin
        if (wait_reg != 6'h0) wait_reg <= wait_reg - 6'h1;
        if (bit_phase || state_reg == ST_DUMMY) begin
          ph_reg <= ~ph_reg;
          if (ph_reg) begin
            cnt_reg <= cnt_reg - 24'h1;
            idx_reg <= idx_reg + 9'h1;
          end
        end
      end
    end
  end

  // outgoing bit of the current phase
  wire logic [3:0] tx_word = tx_base + idx_reg[8:5];
  wire logic       be_tx   = user_reg[B_WR_BE];
  logic tx_bit;
  always_comb begin
    tx_bit = 1'b0;
    case (state_reg)
      ST_CMD: tx_bit = cmd_val[{be_tx ? ~idx_reg[3] : idx_reg[3],
                                ~idx_reg[2:0]}];
      ST_ADDR: tx_bit = addr_val_reg[lane_pos(idx_reg[4:0], be_tx)];
      ST_WRITE: tx_bit = buf_reg[tx_word][lane_pos(idx_reg[4:0], be_tx)];
      default: tx_bit = 1'b0;
    endcase
  end

  // master drive point and sample point
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mosi_reg <= 1'b0;
    end else if (~out_eff || lead_tick || ~bit_phase) begin
      mosi_reg <= tx_bit;
    end
  end

  wire logic m_rx_line = user_reg[B_THREE_LINE] ? pin_s.mosi : pin_s.miso;
  wire logic m_sample  = (out_eff ? trail_tick : lead_tick) &
                         (state_reg == ST_READ ||
                          (state_reg == ST_WRITE && full_dup));

  // slave engine on the sampled pin clock
  wire logic s_active = slave_mode & ~pin_s.cs_n;
  wire logic s_rise   = pin_s.sclk & ~s_sclk_prev_reg;
  wire logic s_fall   = ~pin_s.sclk & s_sclk_prev_reg;
  wire logic s_sample = s_active & (in_eff ? s_fall : s_rise);
  wire logic s_drive  = s_active & (in_eff ? s_rise : s_fall);
  wire logic [3:0] s_tx_word = tx_base + s_idx_reg[8:5];

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s_sclk_prev_reg <= 1'b0;
      s_idx_reg       <= 9'h0;
    end else begin
      s_sclk_prev_reg <= pin_s.sclk;
      if (!s_active) s_idx_reg <= 9'h0;
      else if (s_sample) s_idx_reg <= s_idx_reg + 9'h1;
    end
  end

  // pin inputs lag SYNC_LAT cycles; master sample waits to match
  logic [SYNC_LAT-1:0]      m_smp_pipe_reg;
  logic [SYNC_LAT-1:0][8:0] m_idx_pipe_reg;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      m_smp_pipe_reg <= '0;
      m_idx_pipe_reg <= '0;
    end else begin
      m_smp_pipe_reg <= {m_smp_pipe_reg[SYNC_LAT-2:0], m_sample};
      m_idx_pipe_reg <= {m_idx_pipe_reg[SYNC_LAT-2:0], idx_reg};
    end
  end

  // received bit into the buffer
  wire logic       rx_we   = m_smp_pipe_reg[SYNC_LAT-1] | s_sample;
  wire logic [8:0] rx_idx  = slave_mode ? s_idx_reg
                                        : m_idx_pipe_reg[SYNC_LAT-1];
  wire logic       rx_bit  = slave_mode ? pin_s.mosi : m_rx_line;
  wire logic [3:0] rx_word = rx_base + rx_idx[8:5];
  wire logic [4:0] rx_pos  = lane_pos(rx_idx[4:0], user_reg[B_RD_BE]);

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_buf
      always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
          buf_reg[gi] <= ZERO_RST;
        end else if (wr_i && hit_buf && addr_i[5:2] == 4'(gi)) begin
          buf_reg[gi] <= wr_data_i;
        end else if (rx_we && rx_word == 4'(gi)) begin
          buf_reg[gi][rx_pos] <= rx_bit;
        end
      end
    end
  endgenerate

  // configuration registers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      user_reg     <= USER_RST;
      user1_reg    <= USER1_RST;
      user2_reg    <= USER2_RST;
      txlen_reg    <= ZERO_RST;
      rxlen_reg    <= ZERO_RST;
      addr_val_reg <= ZERO_RST;
      pincfg_reg   <= ZERO_RST;
    end else if (wr_i) begin
      if (addr_i == OFS_USER) user_reg <= wr_data_i;
      else if (addr_i == OFS_USER1) user1_reg[7:0] <= wr_data_i[7:0];
      else if (addr_i == OFS_USER2) user2_reg <= wr_data_i;
      else if (addr_i == OFS_TXLEN) txlen_reg <= {8'h00, wr_data_i[23:0]};
      else if (addr_i == OFS_RXLEN) rxlen_reg <= {8'h00, wr_data_i[23:0]};
      else if (addr_i == OFS_ADDR) addr_val_reg <= wr_data_i;
      else if (addr_i == OFS_PINCFG) pincfg_reg <= {18'h0, wr_data_i[13:0]};
    end
  end

  // status code of the sequencer
  logic [2:0] st_code;
  always_comb begin
    case (state_reg)
      ST_SETUP: st_code = 3'h1;
      ST_CMD, ST_ADDR: st_code = 3'h2;
      ST_WRITE: st_code = 3'h5;
      ST_READ: st_code = 3'h4;
      ST_DUMMY: st_code = 3'h6;
      ST_HOLD, ST_DONE: st_code = 3'h7;
      default: st_code = 3'h0;
    endcase
  end

  // read mux; unmapped reads as zero
  logic [31:0] rd_mux;
  always_comb begin
    if (hit_buf) rd_mux = buf_reg[addr_i[5:2]];
    else if (addr_i == OFS_CTRL) rd_mux = {13'h0, state_reg != ST_IDLE, 18'h0};
    else if (addr_i == OFS_ADDR) rd_mux = addr_val_reg;
    else if (addr_i == OFS_USER) rd_mux = user_reg;
    else if (addr_i == OFS_USER1) rd_mux = user1_reg;
    else if (addr_i == OFS_USER2) rd_mux = user2_reg;
    else if (addr_i == OFS_TXLEN) rd_mux = txlen_reg;
    else if (addr_i == OFS_RXLEN) rd_mux = rxlen_reg;
    else if (addr_i == OFS_PINCFG) rd_mux = pincfg_reg;
    else if (addr_i == OFS_STATUS) rd_mux = {29'h0, st_code};
    else rd_mux = ZERO_RST;
  end

  // pin and read-data flops
  wire logic m_busy  = ~slave_mode & (state_reg != ST_IDLE)
                       & (state_reg != ST_DONE);
  wire logic clk_run = bit_phase |
                       (state_reg == ST_DUMMY & ~user_reg[B_DUMMY_GATE]);
  wire logic drive_mosi = bit_phase & ~(user_reg[B_THREE_LINE] &
                          state_reg == ST_READ);
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rd_data_o  <= ZERO_RST;
      spi_pins_o <= '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0, mosi_oe: 1'b0,
                      miso: 1'b0, miso_oe: 1'b0};
    end else begin
      if (rd_i) rd_data_o <= rd_mux;
      spi_pins_o.cs_n    <= ~m_busy;
      // out_eff launches on the leading edge; otherwise trailing-edge launch, bit settles before the leading edge
      spi_pins_o.mosi    <= out_eff ? mosi_reg : tx_bit;
      spi_pins_o.mosi_oe <= m_busy & drive_mosi;
      spi_pins_o.miso_oe <= s_active & ~user_reg[B_THREE_LINE];
      if (s_drive) begin
        spi_pins_o.miso <= buf_reg[s_tx_word][lane_pos(s_idx_reg[4:0],
                                                        be_tx)];
      end
      if (clk_run && half_tick) begin
        spi_pins_o.sclk <= ~ph_reg ? ~idle_lvl : idle_lvl;
      end else if (!clk_run) begin
        spi_pins_o.sclk <= idle_lvl;
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence seq_cs_fall;
    $fell(spi_pins_o.cs_n);
  endsequence
  sequence seq_clk_idle4;
    (spi_pins_o.sclk == idle_lvl)[*4];
  endsequence

  AST_CMD_ONLY_EN: assert property (
    state_reg == ST_CMD |-> user_reg[B_CMD_EN] && !full_dup)
    else $error("command phase without enable");
  AST_ADDR_ONLY_EN: assert property (
    $rose(state_reg == ST_ADDR) |-> $past(en_addr))
    else $error("address phase without enable");
  AST_DUMMY_ONLY_EN: assert property (
    state_reg == ST_DUMMY |-> en_dummy)
    else $error("dummy phase without enable");
  AST_READ_NO_WRITE: assert property (
    state_reg == ST_READ && user_reg[B_THREE_LINE] |-> ##2
      !spi_pins_o.mosi_oe || state_reg != ST_READ)
    else $error("line driven during three-line read");
  AST_WRITE_ONLY_EN: assert property (
    state_reg == ST_WRITE |-> en_wr)
    else $error("write phase without enable");
  AST_DUMMY_GATED: assert property (
    state_reg == ST_DUMMY && user_reg[B_DUMMY_GATE] ##1
      state_reg == ST_DUMMY |-> spi_pins_o.sclk == idle_lvl)
    else $error("clock toggled in gated dummy");
  AST_SETUP_QUIET: assert property (
    seq_cs_fall |-> seq_clk_idle4)
    else $error("clock edge too soon after select");
  AST_CS_HELD: assert property (
    bit_phase |=> !spi_pins_o.cs_n)
    else $error("select released inside transaction");
  AST_ORDER: assert property (
    state_reg == ST_WRITE |=> !(state_reg inside {ST_CMD, ST_ADDR,
                                                  ST_DUMMY}))
    else $error("phase order broken");
  AST_SLAVE_NO_START: assert property (
    slave_mode && state_reg == ST_IDLE |=> state_reg == ST_IDLE)
    else $error("master sequence started in slave mode");

endmodule
